// ### dsb_regs.svh
`ifndef DSB_REGS_SVH
`define DSB_REGS_SVH

// Generator register offsets
`define DSB_G_CTRL        8'h00
`define DSB_G_DLID        8'h04
`define DSB_G_GROUP       8'h08
`define DSB_G_BSIZE       8'h0C
`define DSB_G_TID         8'h10
`define DSB_G_SENT        8'h14

// Generator control bit positions
`define DSB_CTRL_SEND     0
`define DSB_CTRL_UPDATE   1
`define DSB_CTRL_PRESET   2
`define DSB_CTRL_CRC      3
`define DSB_CTRL_TWOLAYER 4
`define DSB_CTRL_SYNC     5
`define DSB_CTRL_BUSY     8

// Receiver register offsets
`define DSB_R_STAT        8'h00
`define DSB_R_TID         8'h04
`define DSB_R_DLID        8'h08
`define DSB_R_BSIZE       8'h0C
`define DSB_R_GOOD        8'h10
`define DSB_R_BAD         8'h14

// Fixed section content
`define DSB_TABLE_ID      8'h3B
`define DSB_RSVD2         2'h3
`define DSB_VERSION       5'h00
`define DSB_CUR_NEXT      1'h1
`define DSB_SEC_NUM       8'h00
`define DSB_PROTO         8'h11
`define DSB_MSG_TYPE      8'h03
`define DSB_MSG_ID        16'h1002
`define DSB_ORIGINATOR    2'h2
`define DSB_RSVD8         8'hFF
`define DSB_ADAPT_LEN     8'h00
`define DSB_WINDOW        8'h00
`define DSB_SEC_LEN       12'h01C
`define DSB_SEC_LEN_MAX   12'hFFD
`define DSB_MSG_LEN       16'h0007
`define DSB_HDR_OVER_MSG  16'h0015
`define DSB_LEN_OVERHEAD  12'h003
`define DSB_TRAILER_IDX   5'h1B
`define DSB_LAST_IDX      5'h1E

// Block size limits and presets
`define DSB_BS_MIN        16'h0001
`define DSB_BS_MAX        16'h0FE2
`define DSB_BS_SYNC       16'h0FDA
`define DSB_BS_RST        16'h0FE2

// Trailer accumulator polynomial and seeds
`define DSB_CRC_POLY      32'h04C11DB7
`define DSB_CRC_INIT      32'hFFFFFFFF
`define DSB_SUM_INIT      32'h00000000

`endif

// ### dsb_pkg.sv
`include "dsb_regs.svh"
package dsb_pkg;

   typedef enum logic [1:0] {
      DSB_IDLE = 2'b01,
      DSB_SEND = 2'b10
   } dsb_gen_state_e;

   typedef logic [31:0] dsb_word_t;

   // One byte through the MSB-first CRC32
   function automatic dsb_word_t dsb_crc_step(input dsb_word_t acc, input logic [7:0] b);
      dsb_word_t c;
      c = acc;
      for (int i = 7; i >= 0; i--) begin
         c = (c[31] ^ b[i]) ? ((c << 1) ^ `DSB_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   // One byte into the additive checksum
   function automatic dsb_word_t dsb_sum_step(input dsb_word_t acc, input logic [7:0] b);
      return acc + {24'h000000, b};
   endfunction

endpackage

// ### dsb_link_if.sv
`timescale 1ns/100ps
interface dsb_link_if;
   logic       valid;
   logic       ready;
   logic [7:0] data;
   logic       first;
   logic       last;

   modport tx (output valid, output data, output first, output last, input ready);
   modport rx (input valid, input data, input first, input last, output ready);
endinterface

// ### dsb_gen.sv
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "dsb_regs.svh"
module dsb_gen
   import dsb_pkg::*;
#(
   parameter int DATA_W = 8
)(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Section byte stream
   dsb_link_if.tx           link
);

   if (DATA_W != 8) begin : g_chk
      $error("dsb_gen serves only an 8-bit link");
   end

   typedef struct packed {
      dsb_gen_state_e fsm;
      logic           pready;
      logic           pslverr;
      logic [31:0]    prdata;
      logic           ssi;
      logic           two_layer;
      logic           sync;
      logic [13:0]    version;
      logic           upd;
      logic [14:0]    group;
      logic [31:0]    dlid;
      logic [15:0]    bsize;
      logic [15:0]    sent;
      logic           pend;
      logic [31:0]    s_tid;
      logic [31:0]    s_dlid;
      logic [15:0]    s_bs;
      logic           s_ssi;
      logic [4:0]     idx;
      logic [31:0]    acc;
      logic           valid;
      logic           first;
      logic           last;
      logic [7:0]     data;
   } dsb_gen_s;

   dsb_gen_s st;
   dsb_gen_s next_st;

   // Sized copies so that single bytes can be selected
   localparam logic [11:0] SEC_LEN = `DSB_SEC_LEN;
   localparam logic [15:0] MSG_ID  = `DSB_MSG_ID;
   localparam logic [15:0] MSG_LEN = `DSB_MSG_LEN;

   function automatic logic addr_ok(input logic [7:0] a);
      case (a)
         `DSB_G_CTRL, `DSB_G_DLID, `DSB_G_GROUP,
         `DSB_G_BSIZE, `DSB_G_TID, `DSB_G_SENT: addr_ok = 1'b1;
         default:                               addr_ok = 1'b0;
      endcase
   endfunction

   // Current transaction id from live settings
   function automatic logic [31:0] tid_of(input dsb_gen_s s);
      tid_of = {`DSB_ORIGINATOR,
                s.version,
                s.two_layer ? s.group : 15'h0000,
                s.upd};
   endfunction

   // Byte of the section at a given position
   function automatic logic [7:0] byte_at(input dsb_gen_s s);
      case (s.idx)
         5'h00:   byte_at = `DSB_TABLE_ID;
         5'h01:   byte_at = {s.s_ssi, ~s.s_ssi, `DSB_RSVD2, SEC_LEN[11:8]};
         5'h02:   byte_at = SEC_LEN[7:0];
         5'h03:   byte_at = s.s_tid[15:8];
         5'h04:   byte_at = s.s_tid[7:0];
         5'h05:   byte_at = {`DSB_RSVD2, `DSB_VERSION, `DSB_CUR_NEXT};
         5'h06:   byte_at = `DSB_SEC_NUM;
         5'h07:   byte_at = `DSB_SEC_NUM;
         5'h08:   byte_at = `DSB_PROTO;
         5'h09:   byte_at = `DSB_MSG_TYPE;
         5'h0A:   byte_at = MSG_ID[15:8];
         5'h0B:   byte_at = MSG_ID[7:0];
         5'h0C:   byte_at = s.s_tid[31:24];
         5'h0D:   byte_at = s.s_tid[23:16];
         5'h0E:   byte_at = s.s_tid[15:8];
         5'h0F:   byte_at = s.s_tid[7:0];
         5'h10:   byte_at = `DSB_RSVD8;
         5'h11:   byte_at = `DSB_ADAPT_LEN;
         5'h12:   byte_at = MSG_LEN[15:8];
         5'h13:   byte_at = MSG_LEN[7:0];
         5'h14:   byte_at = s.s_dlid[31:24];
         5'h15:   byte_at = s.s_dlid[23:16];
         5'h16:   byte_at = s.s_dlid[15:8];
         5'h17:   byte_at = s.s_dlid[7:0];
         5'h18:   byte_at = s.s_bs[15:8];
         5'h19:   byte_at = s.s_bs[7:0];
         5'h1A:   byte_at = `DSB_WINDOW;
         5'h1B:   byte_at = s.acc[31:24];
         5'h1C:   byte_at = s.acc[23:16];
         5'h1D:   byte_at = s.acc[15:8];
         5'h1E:   byte_at = s.acc[7:0];
         default: byte_at = 8'h00;
      endcase
   endfunction

   always_comb begin
      logic       wr;
      logic [7:0] b;
      wr      = 1'b0;
      b       = 8'h00;
      next_st = st;

      // Register access, answered in the access phase
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      if (psel && !penable) begin
         next_st.pready  = 1'b1;
         next_st.pslverr = !addr_ok(paddr);
         case (paddr)
            `DSB_G_CTRL:  next_st.prdata = {23'h000000, st.fsm == DSB_SEND, 2'h0, st.sync,
                                            st.two_layer, st.ssi, 2'h0, st.pend};
            `DSB_G_DLID:  next_st.prdata = st.dlid;
            `DSB_G_GROUP: next_st.prdata = {17'h00000, st.group};
            `DSB_G_BSIZE: next_st.prdata = {16'h0000, st.bsize};
            `DSB_G_TID:   next_st.prdata = tid_of(st);
            `DSB_G_SENT:  next_st.prdata = {16'h0000, st.sent};
            default:      next_st.prdata = 32'h00000000;
         endcase
      end
      wr = psel && penable && st.pready && pwrite && !st.pslverr;
      if (wr) begin
         case (paddr)
            `DSB_G_CTRL: begin
               next_st.ssi       = pwdata[`DSB_CTRL_CRC];
               next_st.two_layer = pwdata[`DSB_CTRL_TWOLAYER];
               next_st.sync      = pwdata[`DSB_CTRL_SYNC];
               if (pwdata[`DSB_CTRL_UPDATE]) begin
                  next_st.version = st.version + 14'h0001;
                  next_st.upd     = ~st.upd;
               end
               if (pwdata[`DSB_CTRL_PRESET]) begin
                  next_st.bsize = pwdata[`DSB_CTRL_SYNC] ? `DSB_BS_SYNC : `DSB_BS_MAX;
               end
               if (pwdata[`DSB_CTRL_SEND]) begin
                  next_st.pend = 1'b1;
               end
            end
            `DSB_G_DLID:  next_st.dlid  = pwdata;
            `DSB_G_GROUP: next_st.group = pwdata[14:0];
            `DSB_G_BSIZE: begin
               if (pwdata[15:0] >= `DSB_BS_MIN && pwdata[15:0] <= `DSB_BS_MAX && pwdata[31:16] == 16'h0000) begin
                  next_st.bsize = pwdata[15:0];
               end
            end
            default: ;
         endcase
      end

      // Section emission
      case (st.fsm)
         DSB_IDLE: begin
            if (st.pend) begin
               next_st.pend   = wr && pwdata[`DSB_CTRL_SEND] && paddr == `DSB_G_CTRL;
               next_st.s_tid  = tid_of(st);
               next_st.s_dlid = st.dlid;
               next_st.s_bs   = st.bsize;
               next_st.s_ssi  = st.ssi;
               next_st.acc    = st.ssi ? `DSB_CRC_INIT : `DSB_SUM_INIT;
               next_st.idx    = 5'h00;
               next_st.fsm    = DSB_SEND;
            end
         end
         DSB_SEND: begin
            if (!st.valid || link.ready) begin
               if (st.valid && st.last) begin
                  next_st.valid = 1'b0;
                  next_st.first = 1'b0;
                  next_st.last  = 1'b0;
                  next_st.sent  = st.sent + 16'h0001;
                  next_st.fsm   = DSB_IDLE;
               end else begin
                  b             = byte_at(st);
                  next_st.data  = b;
                  next_st.valid = 1'b1;
                  next_st.first = st.idx == 5'h00;
                  next_st.last  = st.idx == `DSB_LAST_IDX;
                  next_st.idx   = st.idx + 5'h01;
                  if (st.idx < `DSB_TRAILER_IDX) begin
                     next_st.acc = st.s_ssi ? dsb_crc_step(st.acc, b) : dsb_sum_step(st.acc, b);
                  end
               end
            end
         end
         default: next_st.fsm = DSB_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st       <= '0;
         st.fsm   <= DSB_IDLE;
         st.bsize <= `DSB_BS_RST;
      end else begin
         st <= next_st;
      end
   end

   assign prdata     = st.prdata;
   assign pready     = st.pready;
   assign pslverr    = st.pslverr;
   assign link.valid = st.valid;
   assign link.data  = st.data;
   assign link.first = st.first;
   assign link.last  = st.last;

endmodule // dsb_gen

// ### dsb_rx.sv
`timescale 1ns/100ps
`include "dsb_regs.svh"
module dsb_rx
   import dsb_pkg::*;
#(
   parameter int DATA_W = 8
)(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Section byte stream
   dsb_link_if.rx           link
);

   if (DATA_W != 8) begin : g_chk
      $error("dsb_rx serves only an 8-bit link");
   end

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        ready;
      logic [11:0] idx;
      logic [7:0]  tbl;
      logic [1:0]  ind;
      logic [11:0] seclen;
      logic [15:0] msglen;
      logic [31:0] tid;
      logic [31:0] dlid;
      logic [15:0] bs;
      logic [31:0] crc;
      logic [31:0] sum;
      logic [31:0] tail;
      logic [6:0]  err;
      logic        ssi;
      logic [31:0] o_tid;
      logic [31:0] o_dlid;
      logic [15:0] o_bs;
      logic [15:0] good;
      logic [15:0] bad;
   } dsb_rx_s;

   dsb_rx_s st;
   dsb_rx_s next_st;

   function automatic logic addr_ok(input logic [7:0] a);
      case (a)
         `DSB_R_STAT, `DSB_R_TID, `DSB_R_DLID,
         `DSB_R_BSIZE, `DSB_R_GOOD, `DSB_R_BAD: addr_ok = 1'b1;
         default:                              addr_ok = 1'b0;
      endcase
   endfunction

   always_comb begin
      logic [11:0] cur;
      logic [6:0]  e;
      logic [7:0]  b;
      cur     = 12'h000;
      e       = 7'h00;
      b       = link.data;
      next_st = st;
      next_st.ready   = 1'b1;
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      if (psel && !penable) begin
         next_st.pready  = 1'b1;
         next_st.pslverr = !addr_ok(paddr);
         case (paddr)
            `DSB_R_STAT:  next_st.prdata = {23'h000000, st.ssi, 1'b0, st.err};
            `DSB_R_TID:   next_st.prdata = st.o_tid;
            `DSB_R_DLID:  next_st.prdata = st.o_dlid;
            `DSB_R_BSIZE: next_st.prdata = {16'h0000, st.o_bs};
            `DSB_R_GOOD:  next_st.prdata = {16'h0000, st.good};
            `DSB_R_BAD:   next_st.prdata = {16'h0000, st.bad};
            default:      next_st.prdata = 32'h00000000;
         endcase
      end
      // Write one to clear; a new error in the same cycle still sets
      if (psel && penable && st.pready && pwrite && paddr == `DSB_R_STAT) begin
         next_st.err = st.err & ~pwdata[6:0];
      end

      if (link.valid && st.ready) begin
         cur = link.first ? 12'h000 : st.idx;
         next_st.idx = cur + 12'h001;
         if (cur == 12'h000) begin
            next_st.crc = `DSB_CRC_INIT;
            next_st.sum = `DSB_SUM_INIT;
         end
         case (cur)
            12'h000: next_st.tbl = b;
            12'h001: begin
               next_st.ind         = b[7:6];
               next_st.seclen[11:8] = b[3:0];
            end
            12'h002: next_st.seclen[7:0] = b;
            12'h00C: next_st.tid[31:24]  = b;
            12'h00D: next_st.tid[23:16]  = b;
            12'h00E: next_st.tid[15:8]   = b;
            12'h00F: next_st.tid[7:0]    = b;
            12'h012: next_st.msglen[15:8] = b;
            12'h013: next_st.msglen[7:0]  = b;
            12'h014: next_st.dlid[31:24] = b;
            12'h015: next_st.dlid[23:16] = b;
            12'h016: next_st.dlid[15:8]  = b;
            12'h017: next_st.dlid[7:0]   = b;
            12'h018: next_st.bs[15:8]    = b;
            12'h019: next_st.bs[7:0]     = b;
            default: ;
         endcase
         if (cur < 12'h003 || cur + 12'h004 < next_st.seclen + `DSB_LEN_OVERHEAD) begin
            next_st.crc = dsb_crc_step(next_st.crc, b);
            next_st.sum = dsb_sum_step(next_st.sum, b);
         end else begin
            next_st.tail = {st.tail[23:0], b};
         end
         if (link.last) begin
            e[0] = next_st.idx != next_st.seclen + `DSB_LEN_OVERHEAD;
            e[1] = next_st.tbl != `DSB_TABLE_ID;
            e[2] = next_st.ind[0] == next_st.ind[1];
            e[3] = next_st.seclen > `DSB_SEC_LEN_MAX;
            e[4] = next_st.msglen + `DSB_HDR_OVER_MSG != {4'h0, next_st.seclen};
            e[5] = next_st.bs < `DSB_BS_MIN || next_st.bs > `DSB_BS_MAX;
            e[6] = next_st.tail != (next_st.ind[1] ? next_st.crc : next_st.sum);
            next_st.err = next_st.err | e;
            next_st.ssi = next_st.ind[1];
            if (e == 7'h00) begin
               next_st.good   = st.good + 16'h0001;
               next_st.o_tid  = next_st.tid;
               next_st.o_dlid = next_st.dlid;
               next_st.o_bs   = next_st.bs;
            end else begin
               next_st.bad = st.bad + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata     = st.prdata;
   assign pready     = st.pready;
   assign pslverr    = st.pslverr;
   assign link.ready = st.ready;

endmodule // dsb_rx

// ### dsb_section_builder_monitor.sv
`timescale 1ns/100ps
`include "dsb_regs.svh"
module dsb_section_builder_monitor (
   // Clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // Link
   input wire logic       valid,
   input wire logic       ready,
   input wire logic [7:0] data,
   input wire logic       first,
   input wire logic       last
);
   logic [4:0]  idx;
   logic [15:0] ext;
   wire         acc = valid && ready;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx <= 5'h00;
         ext <= 16'h0000;
      end else if (acc) begin
         idx <= last ? 5'h00 : idx + 5'h01;
         if (idx == 5'h03) ext[15:8] <= data;
         if (idx == 5'h04) ext[7:0] <= data;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_stall; valid && !ready; endsequence
   sequence s_end; acc && last; endsequence
   sequence s_hdr; data == 8'h11 ##1 data == 8'h03 ##1 data == 8'h10 ##1 data == 8'h02; endsequence
   sequence s_tail; data == 8'hFF ##1 data == 8'h00 ##1 data == 8'h00 ##1 data == 8'h07; endsequence
   chk_first_table: assert property (valid && first |-> data == `DSB_TABLE_ID && idx == 5'h00)
      else $error("table id byte wrong");
   chk_priv_inv: assert property (valid && idx == 5'h01 |-> data[6] == !data[7])
      else $error("private bit not inverse");
   chk_len_rsvd: assert property (valid && idx == 5'h01 |-> data[5:0] == 6'h30)
      else $error("reserved or length high wrong");
   chk_sec_len: assert property (valid && idx == 5'h02 |-> data == 8'h1C)
      else $error("section length wrong");
   chk_ext_tid: assert property (valid && (idx == 5'h0E || idx == 5'h0F)
      |-> data == (idx == 5'h0E ? ext[15:8] : ext[7:0]))
      else $error("extension differs from tid");
   chk_ver_cur: assert property (valid && idx == 5'h05 |-> data == 8'hC1)
      else $error("version or current bit wrong");
   chk_sec_num: assert property (valid && (idx == 5'h06 || idx == 5'h07) |-> data == 8'h00)
      else $error("section number not zero");
   chk_msg_hdr: assert property (acc && idx == 5'h08 |-> s_hdr)
      else $error("message header wrong");
   chk_originator: assert property (valid && idx == 5'h0C |-> data[7:6] == 2'b10)
      else $error("originator wrong");
   chk_adapt_len: assert property (acc && idx == 5'h10 |-> s_tail)
      else $error("reserved adaptation or length wrong");
   chk_window_zero: assert property (valid && idx == 5'h1A |-> data == 8'h00)
      else $error("window size not zero");
   chk_last_pos: assert property (valid |-> last == (idx == 5'h1E) && first == (idx == 5'h00))
      else $error("framing position wrong");
   chk_hold_stall: assert property (s_stall |=> valid && $stable(data) && $stable(last))
      else $error("byte dropped while stalled");
   chk_frame_gap: assert property (s_end |=> !valid)
      else $error("no idle after section");
endmodule // dsb_section_builder_monitor

// ### dsb_section_builder_bench.sv
`timescale 1ns/100ps
`include "dsb_regs.svh"
module dsb_section_builder_bench
   import dsb_pkg::*;
;
   logic        pclk, presetn, penable, pwrite, er;
   logic [2:0]  psel, rdy, serr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd, m_dlid, tid;
   logic [31:0] prd [3];
   logic [7:0]  sec [31];
   logic [7:0]  rxq [$];
   logic        m_upd, m_two, m_ssi, m_sync;
   logic [14:0] m_grp;
   logic [15:0] m_bs;
   int          fail_count, n_tests, seed, cyc, k, m_ver, m_sent;
   dsb_link_if lk();
   dsb_link_if lk2();
   dsb_gen dsb_gen_inst (.pclk(pclk), .presetn(presetn), .psel(psel[0]), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prd[0]), .pready(rdy[0]), .pslverr(serr[0]), .link(lk.tx));
   dsb_rx dsb_rx_inst (.pclk(pclk), .presetn(presetn), .psel(psel[1]), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prd[1]), .pready(rdy[1]), .pslverr(serr[1]), .link(lk.rx));
   // Receiver fed by the bench with one faulty section
   dsb_rx dsb_rx_inst_b (.pclk(pclk), .presetn(presetn), .psel(psel[2]), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prd[2]), .pready(rdy[2]), .pslverr(serr[2]), .link(lk2.rx));
   dsb_section_builder_monitor mon (.pclk(pclk), .presetn(presetn), .valid(lk.valid), .ready(lk.ready),
      .data(lk.data), .first(lk.first), .last(lk.last));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (lk.valid === 1'b1 && lk.ready === 1'b1) rxq.push_back(lk.data);
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   task finish_test;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      chk32(nm, {24'h000000, e}, {24'h000000, g});
   endtask
   task apb(input int s, input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel[s] <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (rdy[s] !== 1'b1);
      rd = prd[s];
      er = serr[s];
      psel    <= 3'b000;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] ctrl(input logic [2:0] cmd);
      return {26'h0, m_sync, m_two, m_ssi, cmd};
   endfunction
   task automatic build;
      logic [31:0] c;
      tid = {2'b10, m_ver[13:0], m_two ? m_grp : 15'h0000, m_upd};
      sec = '{8'h3B, {m_ssi, ~m_ssi, 6'h30}, 8'h1C, tid[15:8], tid[7:0], 8'hC1, 8'h00, 8'h00, 8'h11, 8'h03,
         8'h10, 8'h02, tid[31:24], tid[23:16], tid[15:8], tid[7:0], 8'hFF, 8'h00, 8'h00, 8'h07, m_dlid[31:24],
         m_dlid[23:16], m_dlid[15:8], m_dlid[7:0], m_bs[15:8], m_bs[7:0], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      c = m_ssi ? 32'hFFFFFFFF : 32'h00000000;
      for (int j = 0; j < 27; j++) begin
         if (m_ssi) for (int b = 7; b >= 0; b--) c = (c[31] ^ sec[j][b]) ? ((c << 1) ^ 32'h04C11DB7) : (c << 1);
         else c = c + {24'h000000, sec[j]};
      end
      for (int j = 0; j < 4; j++) sec[27 + j] = c[31 - 8 * j -: 8];
   endtask
   task automatic send_check;
      int t;
      t = 0;
      apb(0, 1'b1, `DSB_G_CTRL, ctrl(3'b001));
      m_sent++;
      build();
      while (rxq.size() < 31 && t < 300) begin
         @(posedge pclk);
         t++;
      end
      for (int j = 0; j < 31; j++) chk8("section byte", sec[j], rxq[j]);
      rxq.delete();
      apb(0, 1'b0, `DSB_G_TID, 32'h0);
      chk32("gen tid", tid, rd);
      apb(0, 1'b0, `DSB_G_SENT, 32'h0);
      chk32("gen sent", m_sent, rd);
      apb(1, 1'b0, `DSB_R_TID, 32'h0);
      chk32("rx tid", tid, rd);
      apb(1, 1'b0, `DSB_R_DLID, 32'h0);
      chk32("rx dlid", m_dlid, rd);
      apb(1, 1'b0, `DSB_R_BSIZE, 32'h0);
      chk32("rx bsize", {16'h0, m_bs}, rd);
      apb(1, 1'b0, `DSB_R_GOOD, 32'h0);
      chk32("rx good", m_sent, rd);
      apb(1, 1'b0, `DSB_R_STAT, 32'h0);
      chk32("rx stat", {23'h0, m_ssi, 8'h00}, rd);
   endtask
   initial begin
      seed = 90;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {lk2.valid, lk2.first, lk2.last, lk2.data} = '0;
      {m_upd, m_two, m_ssi, m_sync, m_grp, m_dlid} = '0;
      m_bs = 16'h0FE2;
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 1'b0, `DSB_G_BSIZE, 32'h0);
      chk32("gen bsize reset", 32'h00000FE2, rd);
      apb(0, 1'b0, 8'h18, 32'h0);
      chk32("unmapped err", 32'h1, {31'h0, er});
      apb(1, 1'b0, 8'h18, 32'h0);
      chk32("rx unmapped err", 32'h1, {31'h0, er});
      $display("test reset done");
      for (k = 0; k < 8; k++) begin
         m_ssi = k[0];
         m_two = k[1];
         m_grp = $random(seed);
         m_dlid = $random(seed);
         m_bs = (k == 2) ? 16'h0001 : (k == 3) ? 16'h0FE2 : 16'h0001 + ($random(seed) & 16'h07FF);
         apb(0, 1'b1, `DSB_G_DLID, m_dlid);
         apb(0, 1'b1, `DSB_G_GROUP, {17'h0, m_grp});
         apb(0, 1'b1, `DSB_G_BSIZE, {16'h0, m_bs});
         if (k[2]) begin
            apb(0, 1'b1, `DSB_G_CTRL, ctrl(3'b010));
            m_ver++;
            m_upd = ~m_upd;
         end
         send_check();
      end
      $display("test sections done");
      apb(0, 1'b1, `DSB_G_BSIZE, 32'h0);
      apb(0, 1'b1, `DSB_G_BSIZE, 32'h00000FE3);
      apb(0, 1'b0, `DSB_G_BSIZE, 32'h0);
      chk32("bsize kept", {16'h0, m_bs}, rd);
      m_sync = 1'b1;
      m_bs = 16'h0FDA;
      apb(0, 1'b1, `DSB_G_CTRL, ctrl(3'b100));
      send_check();
      apb(0, 1'b0, `DSB_G_CTRL, 32'h0);
      chk32("gen ctrl", ctrl(3'b000), rd);
      $display("test block size done");
      build();
      sec[0] = 8'h3C;
      @(posedge pclk);
      for (k = 0; k < 31; k++) begin
         lk2.valid <= 1'b1;
         lk2.data  <= sec[k];
         lk2.first <= (k == 0);
         lk2.last  <= (k == 30);
         do @(posedge pclk); while (lk2.ready !== 1'b1);
      end
      lk2.valid <= 1'b0;
      lk2.data  <= ~sec[30];
      lk2.last  <= 1'b0;
      apb(2, 1'b0, `DSB_R_STAT, 32'h0);
      chk32("bad stat", 32'h42, rd & 32'h7F);
      apb(2, 1'b0, `DSB_R_BAD, 32'h0);
      chk32("bad count", 32'h1, rd);
      apb(2, 1'b1, `DSB_R_STAT, 32'h7F);
      apb(2, 1'b0, `DSB_R_STAT, 32'h0);
      chk32("stat cleared", 32'h0, rd & 32'h7F);
      $display("test faulty section done");
      finish_test();
   end
endmodule // dsb_section_builder_bench
